/* File: adc_ctrl_consts.svh */
// Offsets, field positions, reset values and timing counts of the converter control block.
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
`define IDX_CTRL_ONE     6'h1c
`define IDX_CTRL_TWO     6'h1d
`define IDX_STATUS       6'h1e
`define IDX_RESULT_HI    6'h1f
`define CTRL_ONE_RESET   8'h10
`define CTRL_TWO_RESET   6'h10
`define C1_START         7
`define C1_MODE_HI       6
`define C1_MODE_LO       5
`define C1_DISABLE       4
`define C1_CHAN_HI       3
`define C1_CHAN_LO       0
`define C2_LADDER        5
`define C2_TIME_HI       3
`define C2_TIME_LO       1
`define ST_DONE          5
`define ST_BUSY          4
`define MODE_OFF         2'h0
`define MODE_SOFT        2'h1
`define MODE_REPEAT      2'h3
`define CONV_T_000       39
`define CONV_T_010       78
`define CONV_T_011       156
`define CONV_T_100       312
`define CONV_T_101       624
`define CONV_T_110       1248
`define SAR_UNITS        13
`define SAMPLE_UNITS     3
`define FIRST_TRIAL      10'h200
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

/* File: adc_ctrl_pkg.sv */
// Types shared by the converter control block.
package adc_ctrl_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE    = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b100
  } state_type;

  typedef enum logic [2:0]
  {
    SEL_NONE,
    SEL_CTRL_ONE,
    SEL_CTRL_TWO,
    SEL_STATUS,
    SEL_RESULT_HI
  } reg_sel_type;

  typedef struct packed
  {
    logic [3:0] channel;
    logic       input_disable;
    logic       ladder_connect;
    logic       sample_hold;
    logic [9:0] trial_code;
  } analog_out_type;
endpackage : adc_ctrl_pkg

/* File: sar_adc_control_logic.sv */
// Control, status and successive comparison logic of the 10-bit converter.
`include "adc_ctrl_consts.svh"

// Overview of operation
// - Mode field: off, software start, repeat.
// - Four-bit channel field drives analog multiplexer.
// - Input disable bit gates the analog inputs.
// - Start bit clears itself the cycle after it is written.
// - Standby resets both control registers, blocks writes.
// - Time field selects 39 to 1248 cycles.
// - Control two bit 5 connects ladder.
// - Control two bits 7:6 read undefined.
// - Result split: high byte, status bits 7:6.
// - Store result and set done together.
// - Done interrupt pulses with each stored result.
// - Reading result high byte clears done.
// - Busy high while converting, cleared on standby.
// - Status bits 3:0 read meaningless.
// - Software mode start bit runs one conversion.
// - Repeat restarts; mode off aborts without storing.
module sar_adc_control_logic
(
  // Clock and reset.
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  // Power control: stop, slow or sleep entered.
  input  wire logic                        standby_req,
  // Register bus, AXI4-Lite slave.
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Analog side.
  output adc_ctrl_pkg::analog_out_type     analog,
  input  wire logic                        comparator_in,
  // Completion event.
  output logic                             conversion_done_interrupt
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic reg_sel_type decode(input logic [7:0] addr);
    if (addr == {`IDX_CTRL_ONE, 2'b00})
      return SEL_CTRL_ONE;
    else if (addr == {`IDX_CTRL_TWO, 2'b00})
      return SEL_CTRL_TWO;
    else if (addr == {`IDX_STATUS, 2'b00})
      return SEL_STATUS;
    else if (addr == {`IDX_RESULT_HI, 2'b00})
      return SEL_RESULT_HI;
    else
      return SEL_NONE;
  endfunction : decode

  // Reserved time codes fall back to the slowest setting, the safe choice.
  function automatic logic [6:0] unit_len(input logic [2:0] code);
    case (code)
      3'h0:    return 7'(`CONV_T_000 / `SAR_UNITS);
      3'h2:    return 7'(`CONV_T_010 / `SAR_UNITS);
      3'h3:    return 7'(`CONV_T_011 / `SAR_UNITS);
      3'h4:    return 7'(`CONV_T_100 / `SAR_UNITS);
      3'h5:    return 7'(`CONV_T_101 / `SAR_UNITS);
      default: return 7'(`CONV_T_110 / `SAR_UNITS);
    endcase
  endfunction : unit_len

  function automatic logic [9:0] trial_next(input logic [9:0] code, input logic [3:0] b,
                                            input logic keep);
    logic [9:0] r;
    r = code;
    if (!keep)
      r[b] = 1'b0;
    if (b != 4'h0)
      r[b - 4'h1] = 1'b1;
    return r;
  endfunction : trial_next

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_one_q;
  logic [5:0]  ctrl_two_q;
  logic [9:0]  result_q;
  logic        done_q;
  logic        irq_q;
  state_type   state_q;
  logic [6:0]  slot_q;
  logic [3:0]  unit_q;
  logic [9:0]  trial_q;
  logic        hold_q;
  logic        cmp_meta_q;
  logic        cmp_q;
  logic [7:0]  awaddr_q;
  logic [7:0]  wbyte_q;
  logic        wlane_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic [1:0]  mode;
  logic        mode_ok;
  logic        busy;
  logic [6:0]  len;
  logic [3:0]  bit_idx;
  logic        slot_end;
  logic        start_ev;
  logic        last_step;
  logic        wr_en;
  reg_sel_type wr_sel;
  logic        rd_take;
  reg_sel_type rd_sel;

  assign mode      = ctrl_one_q[`C1_MODE_HI:`C1_MODE_LO];
  assign mode_ok   = (mode == `MODE_SOFT) || (mode == `MODE_REPEAT);
  assign busy      = (state_q != ST_IDLE);
  assign len       = unit_len(ctrl_two_q[`C2_TIME_HI:`C2_TIME_LO]);
  assign bit_idx   = 4'(`SAR_UNITS - 1) - unit_q;
  assign slot_end  = (slot_q == len - 7'h1);
  assign start_ev  = (state_q == ST_IDLE) && ctrl_one_q[`C1_START] && mode_ok;
  assign last_step = (state_q == ST_CONVERT) && mode_ok && slot_end
                     && (unit_q == 4'(`SAR_UNITS - 1));
  assign wr_en     = !awready_q && !wready_q && !bvalid_q;
  assign wr_sel    = decode(awaddr_q);
  assign rd_take   = s_axi_arvalid && arready_q;
  assign rd_sel    = decode(s_axi_araddr);

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign analog.channel        = ctrl_one_q[`C1_CHAN_HI:`C1_CHAN_LO];
  assign analog.input_disable  = ctrl_one_q[`C1_DISABLE];
  assign analog.ladder_connect = ctrl_two_q[`C2_LADDER];
  assign analog.sample_hold    = hold_q;
  assign analog.trial_code     = trial_q;
  assign conversion_done_interrupt = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Address and data are held until both have arrived, so either order works.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      awaddr_q  <= 8'h00;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awaddr_q  <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wbyte_q  <= s_axi_wdata[7:0];
        wlane_q  <= s_axi_wstrb[0];
        wready_q <= 1'b0;
      end
      if (wr_en)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end
    else if (rd_take)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= `RESP_OKAY;
      // Undefined and unstable bits are returned as zero.
      if (rd_sel == SEL_CTRL_ONE)
        rdata_q <= {24'h00_0000, ctrl_one_q};
      else if (rd_sel == SEL_CTRL_TWO)
        rdata_q <= {26'h0, ctrl_two_q};
      else if (rd_sel == SEL_STATUS)
        rdata_q <= {24'h00_0000, result_q[1:0], done_q, busy, 4'h0};
      else if (rd_sel == SEL_RESULT_HI)
        rdata_q <= {24'h00_0000, result_q[9:2]};
      else
      begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= `RESP_SLVERR;
      end
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst || standby_req)
      ctrl_one_q <= `CTRL_ONE_RESET;
    else if (wr_en && wlane_q && (wr_sel == SEL_CTRL_ONE))
      ctrl_one_q <= wbyte_q;
    else
      ctrl_one_q[`C1_START] <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || standby_req)
      ctrl_two_q <= `CTRL_TWO_RESET;
    else if (wr_en && wlane_q && (wr_sel == SEL_CTRL_TWO))
      ctrl_two_q <= wbyte_q[5:0];
  end

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cmp_meta_q <= 1'b0;
      cmp_q      <= 1'b0;
    end
    else
    begin
      cmp_meta_q <= comparator_in;
      cmp_q      <= cmp_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Successive comparison sequencer
  // ----------------------------------------------------------------
  // Each conversion is 13 equal slots: three to sample, ten to resolve bits.
  // The comparator is read on a slot's last cycle, two cycles after the ladder moved,
  // which covers the synchroniser at the shortest slot of three cycles.
  always_ff @(posedge sys_clk)
  begin
    if (rst || standby_req)
    begin
      state_q <= ST_IDLE;
      slot_q  <= 7'h00;
      unit_q  <= 4'h0;
      trial_q <= 10'h000;
      hold_q  <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start_ev)
          begin
            state_q <= ST_SAMPLE;
            slot_q  <= 7'h00;
            unit_q  <= 4'h0;
            trial_q <= `FIRST_TRIAL;
            hold_q  <= 1'b1;
          end
        end
        ST_SAMPLE,
        ST_CONVERT:
        begin
          if (!mode_ok)
          begin
            state_q <= ST_IDLE;
            hold_q  <= 1'b0;
          end
          else if (!slot_end)
            slot_q <= slot_q + 7'h1;
          else if (state_q == ST_SAMPLE)
          begin
            slot_q <= 7'h00;
            unit_q <= unit_q + 4'h1;
            if (unit_q == 4'(`SAMPLE_UNITS - 1))
            begin
              state_q <= ST_CONVERT;
              hold_q  <= 1'b0;
            end
          end
          else if (!last_step)
          begin
            slot_q  <= 7'h00;
            unit_q  <= unit_q + 4'h1;
            trial_q <= trial_next(trial_q, bit_idx, cmp_q);
          end
          else
          begin
            slot_q  <= 7'h00;
            unit_q  <= 4'h0;
            trial_q <= `FIRST_TRIAL;
            if (mode == `MODE_REPEAT)
            begin
              state_q <= ST_SAMPLE;
              hold_q  <= 1'b1;
            end
            else
              state_q <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result, done flag and interrupt
  // ----------------------------------------------------------------
  // A finishing conversion wins over a clearing read in the same cycle.
  always_ff @(posedge sys_clk)
  begin
    if (rst || standby_req)
    begin
      result_q <= 10'h000;
      done_q   <= 1'b0;
      irq_q    <= 1'b0;
    end
    else
    begin
      irq_q <= last_step;
      if (last_step)
      begin
        result_q <= trial_next(trial_q, 4'h0, cmp_q);
        done_q   <= 1'b1;
      end
      else if ((rd_take && (rd_sel == SEL_RESULT_HI)) || start_ev)
        done_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [10:0] run_len_q;
  always_ff @(posedge sys_clk)
  begin
    if (rst || !busy || last_step)
      run_len_q <= 11'h001;
    else
      run_len_q <= run_len_q + 11'h001;
  end

  default clocking chk_cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_start_selfclear: assert property (ctrl_one_q[`C1_START] && !wr_en |=> !ctrl_one_q[`C1_START])
    else $error("start bit did not clear");
  chk_standby_init: assert property (standby_req |=> ctrl_one_q == `CTRL_ONE_RESET
                                      && ctrl_two_q == `CTRL_TWO_RESET)
    else $error("control registers not initialised in standby");
  chk_standby_idle: assert property (standby_req |=> !busy && !irq_q)
    else $error("busy not cleared in standby");
  chk_conv_length: assert property (last_step |-> run_len_q == 11'(`SAR_UNITS) * 11'(len))
    else $error("conversion length wrong");
  chk_store_done_irq: assert property (last_step && !standby_req |=> done_q && irq_q ##1 !irq_q)
    else $error("done or interrupt not raised with result");
  chk_irq_cause: assert property ($rose(irq_q) |-> $past(busy) && done_q)
    else $error("interrupt without a finished conversion");
  chk_soft_start: assert property (start_ev && !standby_req && mode == `MODE_SOFT |=> busy && hold_q)
    else $error("software start did not begin conversion");
  chk_mode_abort: assert property (busy && mode == `MODE_OFF |=> !busy ##1 !irq_q)
    else $error("disable did not halt conversion");
  chk_read_clear: assert property (rd_take && rd_sel == SEL_RESULT_HI && !last_step |=> !done_q)
    else $error("result read did not clear done");
  chk_status_low: assert property (rvalid_q && $past(rd_sel) == SEL_STATUS && $rose(rvalid_q)
                                    |-> rdata_q[3:0] == 4'h0)
    else $error("status low bits not zero");

  cov_soft_conv: cover property (start_ev && mode == `MODE_SOFT ##[1:1000] irq_q);
  cov_repeat_two: cover property (irq_q && mode == `MODE_REPEAT ##[1:1000] irq_q);
  cov_abort: cover property (busy && mode == `MODE_OFF);
endmodule : sar_adc_control_logic

/* File: analog_front_model.sv */
// Behavioural sample-hold and comparator facing the converter control block.
module analog_front_model
(
  // Analog side of the block.
  input  wire adc_ctrl_pkg::analog_out_type analog,
  output logic                              comparator_in,
  // Low six bits of the level presented on the selected channel.
  input  wire logic [5:0]                   level_low
);
  import adc_ctrl_pkg::*;

  // ----------------------------------------
  // Hold and compare
  // ----------------------------------------
  logic [9:0] held;

  initial held = 10'h000;

  // The level is frozen when sampling ends, so a late channel change cannot move the result.
  always @(*)
    if (analog.sample_hold)
      held = analog.input_disable ? 10'h000 : {analog.channel, level_low};

  // The trial bit is kept while the held level is at or above the ladder.
  assign comparator_in = held >= analog.trial_code;
endmodule : analog_front_model

/* File: tb_sar_adc_control_logic.sv */
// Self-checking testbench of the converter control block.
module tb_sar_adc_control_logic;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_ctrl_pkg::*;

  // ----------------------------------------
  // Signals and table
  // ----------------------------------------
  typedef struct packed
  {
    logic [3:0]  ch;
    logic        dis;
    logic [2:0]  tc;
    logic [5:0]  off;
    logic [10:0] t;
  } row_type;

  row_type rows [8] = '{
    '{4'h0, 1'b0, 3'h0, 6'h05, 11'h027},
    '{4'h3, 1'b0, 3'h2, 6'h3a, 11'h04e},
    '{4'h7, 1'b0, 3'h3, 6'h2c, 11'h09c},
    '{4'hb, 1'b0, 3'h4, 6'h11, 11'h138},
    '{4'he, 1'b0, 3'h5, 6'h3f, 11'h270},
    '{4'hf, 1'b0, 3'h6, 6'h00, 11'h4e0},
    '{4'h5, 1'b1, 3'h0, 6'h2a, 11'h027},
    '{4'h9, 1'b0, 3'h1, 6'h16, 11'h4e0}};

  logic           sys_clk = 1'b0;
  logic           rst = 1'b1;
  logic           standby_req = 1'b0;
  logic [7:0]     awaddr = 8'h00;
  logic [7:0]     araddr = 8'h00;
  logic [31:0]    wdata = 32'h00000000;
  logic           awvalid = 1'b0;
  logic           wvalid = 1'b0;
  logic           bready = 1'b0;
  logic           arvalid = 1'b0;
  logic           rready = 1'b0;
  logic [5:0]     off = 6'h00;
  logic           awready, wready, bvalid, arready, rvalid, irq, cmp;
  logic [1:0]     bresp, rresp;
  logic [31:0]    rdata;
  analog_out_type analog;
  logic [9:0]     lv;
  logic [7:0]     d;
  logic [1:0]     rs;
  logic [1:0]     bs;
  row_type        r;
  int             fails = 0;
  int             checked = 0;
  int             irqs = 0;
  int             n, k;

  sar_adc_control_logic i_sar_adc_control_logic
  (
    .sys_clk(sys_clk), .rst(rst), .standby_req(standby_req),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .analog(analog), .comparator_in(cmp), .conversion_done_interrupt(irq)
  );

  analog_front_model i_analog_front_model
  (
    .analog(analog), .comparator_in(cmp), .level_low(off)
  );

  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (irq === 1'b1)
      irqs <= irqs + 1;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits for the answer however long it takes; only the watchdog ends a hung transfer.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] s);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    v = rdata[7:0];
    s = rresp;
    rready <= 1'b0;
  endtask : rd

  // Counts edges until the completion pulse is sampled; the cap keeps a dead block from hanging here.
  task automatic wait_irq(output int c);
    c = 0;
    do
    begin
      @(posedge sys_clk);
      c++;
    end
    while (irq !== 1'b1 && c < 3000);
    chk("irq wait", 1, irq);
  endtask : wait_irq

  task automatic reg_defaults();
    logic [7:0] ra [4] = '{8'h70, 8'h74, 8'h7c, 8'h78};
    logic [7:0] rv [4] = '{8'h10, 8'h10, 8'h00, 8'h00};
    logic [7:0] v;
    logic [1:0] s;
    for (int i = 0; i < 4; i++)
    begin
      rd(ra[i], v, s);
      chk("default", rv[i], v);
    end
  endtask : reg_defaults

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    #1ms;
    fails++;
    wrap_up();
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      r = rows[i];
      lv = r.dis ? 10'h000 : {r.ch, r.off};
      off <= r.off;
      wr(8'h74, {2'b00, r.ch[0], 1'b1, r.tc, 1'b0});
      wr(8'h70, {3'b001, r.dis, r.ch});
      chk("channel", r.ch, analog.channel);
      chk("disable", r.dis, analog.input_disable);
      chk("ladder", r.ch[0], analog.ladder_connect);
      wr(8'h70, {3'b101, r.dis, r.ch});
      @(posedge sys_clk);
      chk("hold", 1, analog.sample_hold);
      chk("first trial", 10'h200, analog.trial_code);
      wait_irq(n);
      chk("latency", 1, n >= r.t && n <= r.t + 2);
      @(posedge sys_clk);
      chk("pulse", 0, irq);
      rd(8'h78, d, rs);
      chk("status", {lv[1:0], 6'h20}, d);
      rd(8'h7c, d, rs);
      chk("high", lv[9:2], d);
      rd(8'h78, d, rs);
      chk("done clear", {lv[1:0], 6'h00}, d);
      rd(8'h70, d, rs);
      chk("start clear", {3'b001, r.dis, r.ch}, d);
      rd(8'h74, d, rs);
      chk("ctrl two", {2'b00, r.ch[0], 1'b1, r.tc, 1'b0}, d);
    end
    // Repeat mode, then an abort that must not store.
    off <= 6'h11;
    wr(8'h74, 8'h10);
    wr(8'h70, 8'he2);
    wait_irq(n);
    wait_irq(n);
    chk("repeat gap", 1, n >= 38 && n <= 40);
    rd(8'h78, d, rs);
    chk("busy on", 1, d[4]);
    k = irqs;
    wr(8'h70, 8'h02);
    rd(8'h78, d, rs);
    chk("busy off", 0, d[4]);
    repeat (60) @(posedge sys_clk);
    chk("no store", k, irqs);
    wr(8'h70, 8'hc2);
    repeat (60) @(posedge sys_clk);
    chk("reserved mode", k, irqs);
    wr(8'h70, 8'ha2);
    repeat (120) @(posedge sys_clk);
    chk("single shot", k + 1, irqs);
    // Standby in mid-conversion.
    wr(8'h74, 8'h1c);
    wr(8'h70, 8'ha2);
    repeat (20) @(posedge sys_clk);
    standby_req <= 1'b1;
    wr(8'h70, 8'h23);
    reg_defaults();
    standby_req <= 1'b0;
    repeat (1300) @(posedge sys_clk);
    chk("standby abort", k + 1, irqs);
    // Second reset, read-only and unmapped places.
    wr(8'h7c, 8'hff);
    chk("ro bresp", 2'h0, bs);
    rd(8'h7c, d, rs);
    chk("read only", 8'h00, d);
    wr(8'h40, 8'h55);
    chk("unmapped bresp", 2'h2, bs);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    reg_defaults();
    rd(8'h40, d, rs);
    chk("unmapped resp", 2'h2, rs);
    chk("unmapped data", 8'h00, d);
    wrap_up();
  end
endmodule : tb_sar_adc_control_logic
